// file: fdx_exception_unit.v
/*
  fdx_exception_unit.v: exception detection, result substitution,
  stall control and fp_control_status for a floating-point unit.
  Assumes the datapath classifies operands and reports rounding
  outcome flags on the same clock; the pipeline honours stall_o.
*/
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "fdx_defines.vh"

// Functional notes
// - inexact on inexact rounding, overflow, or flushed untrapped underflow
// - stall risky ops; with inexact trap stall all multicycle ops
// - inexact trap keeps destination; otherwise write rounded result
// - invalid for inf-inf, 0*inf, 0/0, inf/inf, sqrt of negative
// - invalid for signalling NaN use and ordered predicates on unordered
// - untrapped invalid writes quiet NaN; trapped leaves operands
// - divide by zero for finite nonzero dividend; signed infinity
// - overflow on rounded magnitude above max; also sets inexact
// - tininess judged after rounding
// - underflow accuracy loss judged as inexact result
// - underflow traps to unimplemented unless flushed and untrapped
// - reserved op or format code traps unimplemented, never disabled
// - denormal or quiet NaN operand of convert/compute traps, moves and compares not
// - fused multiply part overflow, underflow or denormal traps
// - float to 64-bit integer out of 53-bit range traps
// - float to 32-bit integer out of range traps
// - 64-bit integer to float beyond 52-bit range traps
// - extended level instruction traps while level disabled
// - status read reports in-flight op; one pending exception only
// - writing zero cause clears pending exceptions
// - cause holds one instruction; risky ops run one at a time
// - overflow or underflow with inexact sets both cause bits
// - cause set; flag when enable clear, else interrupt
// - untrapped overflow substitution per rounding mode
// - untrapped underflow substitution per rounding mode
module fdx_exception_unit #(
  parameter [4:0] TRAP_CODE = 5'h0f // arbitrary value
) (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // register port
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output wire [31:0] rdata_o,
  // issue side
  input wire op_issue_i,
  input wire may_except_i,
  input wire multicycle_i,
  // completion side
  input wire op_done_i,
  input wire [3:0] op_class_i,
  input wire eff_sub_i,
  input wire cmp_sig_i,
  input wire reserved_i,
  input wire bad_fmt_i,
  input wire ext_level_i,
  input wire [5:0] opa_kind_i,
  input wire [5:0] opb_kind_i,
  input wire inexact_i,
  input wire overflow_i,
  input wire tiny_i,
  input wire res_zero_i,
  input wire res_neg_i,
  input wire mul_ovf_i,
  input wire mul_unf_i,
  input wire mul_den_i,
  input wire [63:0] int_val_i,
  input wire int_wide_i,
  // pipeline and trap side
  output wire stall_o,
  output wire wr_en_o,
  output wire [2:0] res_sel_o,
  output wire res_sign_o,
  output wire trap_o,
  output wire [4:0] trap_code_o
);

  reg [31:0] csr_r;
  reg busy_r;
  reg pend_r;
  reg stall_r;
  reg wr_en_r;
  reg [2:0] sel_r;
  reg sign_r;
  reg [4:0] code_r;
  reg [31:0] rdata_r;

  wire [1:0] rm = csr_r[`FDX_RM_HI:`FDX_RM_LO];
  wire [4:0] en = csr_r[`FDX_EN_HI:`FDX_EN_LO];
  wire flush_sel = csr_r[`FDX_FLUSH_BIT];
  wire ext_en = csr_r[`FDX_EXT_BIT];

  // evaluation of the completing operation
  reg x_v;
  reg x_z;
  reg x_o;
  reg x_u;
  reg x_i;
  reg x_e;
  reg tiny;
  reg nan_a;
  reg nan_b;
  reg fin_a;
  reg arith;
  reg trap_nxt;
  reg [5:0] cause_nxt;
  reg [2:0] sel_nxt;
  reg sign_nxt;
  wire a_snan = opa_kind_i[`FDX_K_SNAN];
  wire b_snan = opb_kind_i[`FDX_K_SNAN];
  wire a_inf = opa_kind_i[`FDX_K_INF];
  wire b_inf = opb_kind_i[`FDX_K_INF];
  wire a_zero = opa_kind_i[`FDX_K_ZERO];
  wire b_zero = opb_kind_i[`FDX_K_ZERO];
  wire a_neg = opa_kind_i[`FDX_K_NEG];
  wire b_neg = opb_kind_i[`FDX_K_NEG];
  wire signed [63:0] ival = int_val_i;

  always @*
  begin
    nan_a = opa_kind_i[`FDX_K_SNAN] | opa_kind_i[`FDX_K_QNAN];
    nan_b = opb_kind_i[`FDX_K_SNAN] | opb_kind_i[`FDX_K_QNAN];
    fin_a = ~a_inf & ~nan_a;
    arith = (op_class_i != `FDX_OP_MOV);
    x_v = 1'b0;
    x_z = 1'b0;
    x_e = 1'b0;
    case (op_class_i)
      `FDX_OP_ADD:
        x_v = eff_sub_i & a_inf & b_inf;
      `FDX_OP_MUL, `FDX_OP_MADD:
        x_v = (a_zero & b_inf) | (a_inf & b_zero);
      `FDX_OP_DIV:
        x_v = (a_zero & b_zero) | (a_inf & b_inf);
      `FDX_OP_SQRT:
        x_v = a_neg & ~a_zero & ~nan_a;
      default:
        x_v = 1'b0;
    endcase
    if (arith && (a_snan || b_snan))
    begin
      x_v = 1'b1;
    end
    if (op_class_i == `FDX_OP_CMP && cmp_sig_i && (nan_a || nan_b))
    begin
      x_v = 1'b1;
    end
    if (op_class_i == `FDX_OP_DIV)
    begin
      x_z = b_zero & fin_a & ~a_zero & ~x_v;
    end
    x_o = overflow_i;
    tiny = tiny_i & ~res_zero_i;
    x_u = tiny & inexact_i;
    x_i = inexact_i | x_o;
    if (tiny && !en[`FDX_X_U] && !en[`FDX_X_I] && flush_sel)
    begin
      x_i = 1'b1;
    end
    if (tiny && (en[`FDX_X_U] || en[`FDX_X_I] || !flush_sel))
    begin
      x_e = 1'b1;
    end
    if (reserved_i || bad_fmt_i)
    begin
      x_e = 1'b1;
    end
    if (arith && op_class_i != `FDX_OP_CMP &&
        (opa_kind_i[`FDX_K_DEN] || opb_kind_i[`FDX_K_DEN] ||
         opa_kind_i[`FDX_K_QNAN] || opb_kind_i[`FDX_K_QNAN]))
    begin
      x_e = 1'b1;
    end
    if (op_class_i == `FDX_OP_MADD && (mul_ovf_i || mul_unf_i || mul_den_i))
    begin
      x_e = 1'b1;
    end
    if (op_class_i == `FDX_OP_F2L &&
        (int_wide_i || ival > $signed(`FDX_L_MAX) || ival < $signed(`FDX_L_MIN)))
    begin
      x_e = 1'b1;
    end
    if (op_class_i == `FDX_OP_F2W &&
        (int_wide_i || ival > $signed(`FDX_W_MAX) || ival < $signed(`FDX_W_MIN)))
    begin
      x_e = 1'b1;
    end
    if (op_class_i == `FDX_OP_L2F &&
        (ival > $signed(`FDX_I2F_MAX) || ival < $signed(`FDX_I2F_MIN)))
    begin
      x_e = 1'b1;
    end
    if (ext_level_i && !ext_en)
    begin
      x_e = 1'b1;
    end
    // unimplemented replaces the standard causes
    if (x_e)
    begin
      cause_nxt = 6'h20;
    end
    else
    begin
      cause_nxt = {1'b0, x_v, x_z, x_o, x_u, x_i};
    end
    trap_nxt = cause_nxt[`FDX_X_E] | (|(cause_nxt[4:0] & en));
    sel_nxt = `FDX_SEL_ROUND;
    sign_nxt = res_neg_i;
    if (x_v)
    begin
      sel_nxt = `FDX_SEL_QNAN;
      sign_nxt = 1'b0;
    end
    else if (x_z)
    begin
      sel_nxt = `FDX_SEL_INF;
      sign_nxt = a_neg ^ b_neg;
    end
    else if (x_o)
    begin
      case (rm)
        `FDX_RN:
          sel_nxt = `FDX_SEL_INF;
        `FDX_RZ:
          sel_nxt = `FDX_SEL_MAXF;
        `FDX_RP:
          sel_nxt = res_neg_i ? `FDX_SEL_MAXF : `FDX_SEL_INF;
        default:
          sel_nxt = res_neg_i ? `FDX_SEL_INF : `FDX_SEL_MAXF;
      endcase
    end
    else if (tiny)
    begin
      case (rm)
        `FDX_RP:
          sel_nxt = res_neg_i ? `FDX_SEL_ZERO : `FDX_SEL_MINF;
        `FDX_RM:
          sel_nxt = res_neg_i ? `FDX_SEL_MINF : `FDX_SEL_ZERO;
        default:
          sel_nxt = `FDX_SEL_ZERO;
      endcase
    end
  end

  // issue control
  wire csr_wr = wr_i && (addr_i == `FDX_ADDR_CSR);
  wire clr_pend = csr_wr && (wdata_i[`FDX_CAUSE_HI:`FDX_CAUSE_LO] == 6'h00);
  wire done_ev = op_done_i && busy_r;
  // stall risky and, with inexact trap, multicycle ops
  wire need_stall = may_except_i || (en[`FDX_X_I] && multicycle_i);
  // no issue taken while one is outstanding
  wire issue_ok = op_issue_i && !busy_r && !pend_r;
  wire busy_nxt = issue_ok ? 1'b1 : (op_done_i ? 1'b0 : busy_r);
  wire pend_set = done_ev && trap_nxt;
  // set wins over software clear
  wire pend_nxt = pend_set ? 1'b1 : (clr_pend ? 1'b0 : pend_r);
  // only an op issued stalled or a pending trap keeps the stall; safe ops must not cost cycles
  wire stall_nxt = (issue_ok ? need_stall : (stall_r && busy_r && !op_done_i)) || pend_nxt;

  // flags accumulate for untrapped standard exceptions
  wire [4:0] flag_new = done_ev ? (cause_nxt[4:0] & ~en) : 5'h00;
  reg [31:0] csr_nxt;
  always @*
  begin
    csr_nxt = csr_r;
    if (csr_wr)
    begin
      csr_nxt = wdata_i;
    end
    csr_nxt[`FDX_FLAG_HI:`FDX_FLAG_LO] = csr_nxt[`FDX_FLAG_HI:`FDX_FLAG_LO] | flag_new;
    // cause reflects just the completing instruction
    if (done_ev)
    begin
      csr_nxt[`FDX_CAUSE_HI:`FDX_CAUSE_LO] = cause_nxt;
    end
  end

  // read path
  reg [31:0] rd_nxt;
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    if (rd_i)
    begin
      if (addr_i == `FDX_ADDR_CSR)
      begin
        // an op completing now is reported in the read
        rd_nxt = csr_nxt;
      end
      else if (addr_i == `FDX_ADDR_STAT)
      begin
        rd_nxt = {24'h00_0000, pend_r, busy_r, 1'b0, code_r};
      end
    end
  end

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      csr_r <= `FDX_CSR_RST;
      busy_r <= 1'b0;
      pend_r <= 1'b0;
      stall_r <= 1'b0;
      wr_en_r <= 1'b0;
      sel_r <= `FDX_SEL_ROUND;
      sign_r <= 1'b0;
      code_r <= 5'h00;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      csr_r <= csr_nxt;
      busy_r <= busy_nxt;
      pend_r <= pend_nxt;
      stall_r <= stall_nxt;
      rdata_r <= rd_nxt;
      wr_en_r <= done_ev && !trap_nxt;
      if (done_ev)
      begin
        sel_r <= sel_nxt;
        sign_r <= sign_nxt;
      end
      if (pend_set)
      begin
        code_r <= TRAP_CODE;
      end
      else if (clr_pend)
      begin
        code_r <= 5'h00;
      end
    end
  end

  assign rdata_o = rdata_r;
  assign stall_o = stall_r;
  assign wr_en_o = wr_en_r;
  assign res_sel_o = sel_r;
  assign res_sign_o = sign_r;
  assign trap_o = pend_r;
  assign trap_code_o = code_r;

endmodule // fdx_exception_unit

// file: fdx_defines.vh
/*
  fdx_defines.vh: offsets, field positions, encodings and limits
  of the floating-point exception unit.
  Assumes inclusion by bare name from the exception unit module.
*/
`ifndef FDX_DEFINES_VH
`define FDX_DEFINES_VH

// register offsets (byte addresses)
`define FDX_ADDR_CSR 4'h0
`define FDX_ADDR_STAT 4'h4

// fp_control_status fields
`define FDX_RM_LO 0
`define FDX_RM_HI 1
`define FDX_FLAG_LO 2
`define FDX_FLAG_HI 6
`define FDX_EN_LO 7
`define FDX_EN_HI 11
`define FDX_CAUSE_LO 12
`define FDX_CAUSE_HI 17
`define FDX_FLUSH_BIT 24
`define FDX_EXT_BIT 25
`define FDX_CSR_RST 32'h0000_0000

// exception bit order in flag/enable/cause fields
`define FDX_X_I 0
`define FDX_X_U 1
`define FDX_X_O 2
`define FDX_X_Z 3
`define FDX_X_V 4
`define FDX_X_E 5

// rounding modes
`define FDX_RN 2'h0
`define FDX_RZ 2'h1
`define FDX_RP 2'h2
`define FDX_RM 2'h3

// operation classes
`define FDX_OP_ADD 4'h0
`define FDX_OP_MUL 4'h1
`define FDX_OP_DIV 4'h2
`define FDX_OP_SQRT 4'h3
`define FDX_OP_ABSNEG 4'h4
`define FDX_OP_MOV 4'h5
`define FDX_OP_CMP 4'h6
`define FDX_OP_F2L 4'h7
`define FDX_OP_F2W 4'h8
`define FDX_OP_L2F 4'h9
`define FDX_OP_CVTF 4'ha
`define FDX_OP_MADD 4'hb

// operand kind bits
`define FDX_K_SNAN 0
`define FDX_K_QNAN 1
`define FDX_K_INF 2
`define FDX_K_ZERO 3
`define FDX_K_DEN 4
`define FDX_K_NEG 5

// result selects
`define FDX_SEL_ROUND 3'h0
`define FDX_SEL_QNAN 3'h1
`define FDX_SEL_INF 3'h2
`define FDX_SEL_MAXF 3'h3
`define FDX_SEL_MINF 3'h4
`define FDX_SEL_ZERO 3'h5

// conversion limits
`define FDX_L_MAX 64'h001F_FFFF_FFFF_FFFF
`define FDX_L_MIN 64'hFFE0_0000_0000_0000
`define FDX_W_MAX 64'h0000_0000_7FFF_FFFF
`define FDX_W_MIN 64'hFFFF_FFFF_8000_0000
`define FDX_I2F_MAX 64'h000F_FFFF_FFFF_FFFF
`define FDX_I2F_MIN 64'hFFF0_0000_0000_0000

`endif

// file: fdx_exception_unit_monitor.sv
/*
  fdx_exception_unit_monitor.sv: port checker for the exception unit.
  Assumes a single clock domain and a bind onto the unit.
*/
`timescale 1ns/1ps
module fdx_exception_unit_monitor #(
  parameter [4:0] TRAP_CODE = 5'h0f // arbitrary value
) (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // register port
  input wire [3:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  // operation flow
  input wire op_issue_i,
  input wire may_except_i,
  input wire op_done_i,
  input wire stall_o,
  input wire wr_en_o,
  input wire trap_o,
  input wire [4:0] trap_code_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wire clr_w = wr_i && addr_i == 4'h0 && wdata_i[17:12] == 6'h00;
  property p_stall; op_issue_i && may_except_i && !stall_o |=> stall_o; endproperty
  a_stall: assert property (p_stall) else $error("no stall after risky issue");
  property p_code; trap_code_o == (trap_o ? TRAP_CODE : 5'h00); endproperty
  a_code: assert property (p_code) else $error("trap code wrong");
  property p_nowr; $rose(trap_o) |-> !wr_en_o; endproperty
  a_nowr: assert property (p_nowr) else $error("destination written on trap");
  property p_wrdone; wr_en_o |-> $past(op_done_i); endproperty
  a_wrdone: assert property (p_wrdone) else $error("write without completion");
  property p_hold; trap_o && !clr_w |=> trap_o; endproperty
  a_hold: assert property (p_hold) else $error("pending trap lost");
  property p_clear; trap_o && clr_w && !op_done_i |-> ##[1:2] !trap_o; endproperty
  a_clear: assert property (p_clear) else $error("cause clear ignored");
  property p_pend; trap_o && $past(trap_o) |-> stall_o; endproperty
  a_pend: assert property (p_pend) else $error("no stall while pending");
  property p_rel; op_done_i && stall_o |=> stall_o == trap_o; endproperty
  a_rel: assert property (p_rel) else $error("stall release wrong");
  property p_cause; $rose(trap_o) |-> $past(op_done_i); endproperty
  a_cause: assert property (p_cause) else $error("trap without completion");
  property p_rd; !$past(rd_i) |-> rdata_o == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("read data outside slot");
  c_trap: cover property ($rose(trap_o));
  c_write: cover property (wr_en_o);
  c_read: cover property (rd_i ##1 rdata_o != 32'h0);
endmodule // fdx_exception_unit_monitor

// file: fdx_pipe_model.sv
/*
  fdx_pipe_model.sv: pipeline and datapath pacing for the exception unit.
  Assumes the bench asks for one op at a time with go_i.
*/
`timescale 1ns/1ps
module fdx_pipe_model (
  // clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // bench request
  input wire go_i,
  input wire [3:0] lat_i,
  // exception unit side
  input wire stall_i,
  output reg op_issue_o,
  output reg op_done_o
);
  reg [3:0] cnt_r;
  wire start_w = go_i && cnt_r == 4'h0 && !stall_i && !op_issue_o && !op_done_o;
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_r <= 4'h0;
      op_issue_o <= 1'h0;
      op_done_o <= 1'h0;
    end
    else
    begin
      op_issue_o <= start_w;
      op_done_o <= cnt_r == 4'h1;
      if (start_w)
        cnt_r <= lat_i;
      else if (cnt_r != 4'h0)
        cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule // fdx_pipe_model

// file: fdx_exception_unit_tb_top.sv
/*
  fdx_exception_unit_tb_top.sv: self-checking bench for the exception unit.
  Assumes fdx_pipe_model paces issue and completion.
*/
`timescale 1ns/1ps
module fdx_exception_unit_tb_top;
  localparam [4:0] TC = 5'h15; // arbitrary value
  reg clk_i = 1'h0;
  reg arst_n_i = 1'h0;
  reg wr = 1'h0, rd = 1'h0, go = 1'h0;
  reg [3:0] addr = 4'h0, cls = 4'h0, lat = 4'h1;
  reg [5:0] ka = 6'h0, kb = 6'h0;
  reg [15:0] fl = 16'h0;
  reg [63:0] iv = 64'h0;
  reg [31:0] wd = 32'h0, d;
  integer errors = 0, n_compared = 0;
  wire [31:0] rdata;
  wire [2:0] sel;
  wire [4:0] code;
  wire iss, done, stall, wen, sgn, trap;
  always #25 clk_i = ~clk_i;
  fdx_exception_unit #(.TRAP_CODE(TC)) DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr), .wdata_i(wd),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .op_issue_i(iss), .may_except_i(fl[15]), .multicycle_i(fl[14]),
    .op_done_i(done), .op_class_i(cls), .eff_sub_i(fl[13]), .cmp_sig_i(fl[12]), .reserved_i(fl[11]),
    .bad_fmt_i(fl[10]), .ext_level_i(fl[9]), .opa_kind_i(ka), .opb_kind_i(kb), .inexact_i(fl[8]),
    .overflow_i(fl[7]), .tiny_i(fl[6]), .res_zero_i(fl[5]), .res_neg_i(fl[4]), .mul_ovf_i(fl[3]),
    .mul_unf_i(fl[2]), .mul_den_i(fl[1]), .int_val_i(iv), .int_wide_i(fl[0]), .stall_o(stall), .wr_en_o(wen),
    .res_sel_o(sel), .res_sign_o(sgn), .trap_o(trap), .trap_code_o(code));
  fdx_pipe_model u_pipe (.clk_i(clk_i), .arst_n_i(arst_n_i), .go_i(go), .lat_i(lat), .stall_i(stall),
    .op_issue_o(iss), .op_done_o(done));
  task cyc;
  begin
    @(posedge clk_i);
    #1;
  end
  endtask
  task end_sim;
  begin
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  task chk(input ok, input [63:0] m);
  begin
    n_compared = n_compared + 1;
    if (!ok)
    begin
      errors = errors + 1;
      $display("Error at %0t: %0s", $time, m);
    end
  end
  endtask
  // a write ignores the returned word; a read leaves it in d
  task bus(input w, input [3:0] a, input [31:0] v);
  begin
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= v;
    cyc;
    d = rdata;
    wr <= 1'h0;
    rd <= 1'h0;
    cyc;
  end
  endtask
  task op(input [31:0] c, input [3:0] k, input [5:0] a, input [5:0] b, input [15:0] f, input [63:0] v,
    input [5:0] ec, input [3:0] es);
    integer i;
    reg t;
  begin
    t = ec[5] | (|(ec[4:0] & c[11:7]));
    bus(1'h1, 4'h0, c);
    cls <= k;
    ka <= a;
    kb <= b;
    fl <= f;
    iv <= v;
    lat <= lat ^ 4'h2;
    go <= 1'h1;
    cyc;
    go <= 1'h0;
    cyc;
    chk(stall === (f[15] | (c[7] & f[14])), "stall");
    i = 0;
    while (done !== 1'h1 && i < 20)
    begin
      cyc;
      i = i + 1;
    end
    if (i == 20)
    begin
      errors = errors + 1;
      $display("Error at %0t: no completion", $time);
      end_sim;
    end
    chk(stall === (f[15] | (c[7] & f[14])), "hold");
    cyc;
    chk(trap === t && wen === !t && stall === t, "outcome");
    if (!t)
      chk(sel === es[2:0] && (es[2:0] < 3'h2 || sgn === es[3]), "result");
    bus(1'h0, 4'h0, 32'h0);
    chk(d[25:0] === {c[25:18], ec, c[11:7], (ec[5] ? 5'h0 : ec[4:0] & ~c[11:7]), c[1:0]}, "csr");
    if (t)
    begin
      bus(1'h0, 4'h4, 32'h0);
      chk(d[7] === 1'h1 && d[4:0] === TC && code === TC, "pending");
      bus(1'h1, 4'h0, c);
      chk(trap === 1'h0, "clear");
    end
  end
  endtask
  initial
  begin
    repeat (2) @(posedge clk_i);
    #1;
    arst_n_i = 1'h1;
    bus(1'h0, 4'h0, 32'h0);
    chk(d === 32'h0, "reset");
    bus(1'h0, 4'h8, 32'h0);
    chk(d === 32'h0, "unmapped");
    op(32'h0, 4'h0, 6'h0, 6'h0, 16'h0, 64'h0, 6'h0, 4'h0);
    op(32'h0, 4'h0, 6'h0, 6'h0, 16'h8100, 64'h0, 6'h1, 4'h0);
    op(32'h0, 4'h0, 6'h0, 6'h0, 16'h8180, 64'h0, 6'h5, 4'h2);
    op(32'h1, 4'h0, 6'h0, 6'h0, 16'h8190, 64'h0, 6'h5, 4'hb);
    op(32'h0, 4'h0, 6'h4, 6'h24, 16'ha000, 64'h0, 6'h10, 4'h1);
    op(32'h0, 4'h1, 6'h8, 6'h24, 16'h8000, 64'h0, 6'h10, 4'h1);
    op(32'h0, 4'h2, 6'h8, 6'h8, 16'h8000, 64'h0, 6'h10, 4'h1);
    op(32'h0, 4'h3, 6'h20, 6'h0, 16'h8000, 64'h0, 6'h10, 4'h1);
    op(32'h0, 4'h2, 6'h20, 6'h8, 16'h8000, 64'h0, 6'h8, 4'ha);
    op(32'h0, 4'h4, 6'h1, 6'h0, 16'h8000, 64'h0, 6'h10, 4'h1);
    op(32'h0, 4'h5, 6'h1, 6'h10, 16'h8000, 64'h0, 6'h0, 4'h0);
    op(32'h800, 4'h6, 6'h2, 6'h0, 16'h9000, 64'h0, 6'h10, 4'h0);
    op(32'h0, 4'h0, 6'h10, 6'h0, 16'h8000, 64'h0, 6'h20, 4'h0);
    op(32'h0, 4'h1, 6'h2, 6'h0, 16'h8000, 64'h0, 6'h20, 4'h0);
    op(32'h0, 4'h0, 6'h0, 6'h0, 16'h8800, 64'h0, 6'h20, 4'h0);
    op(32'h0, 4'h0, 6'h0, 6'h0, 16'h8200, 64'h0, 6'h20, 4'h0);
    op(32'h0200_0000, 4'h0, 6'h0, 6'h0, 16'h8200, 64'h0, 6'h0, 4'h0);
    op(32'h0, 4'hb, 6'h0, 6'h0, 16'h8008, 64'h0, 6'h20, 4'h0);
    op(32'h0, 4'h7, 6'h0, 6'h0, 16'h8000, 64'h0020_0000_0000_0000, 6'h20, 4'h0);
    op(32'h0, 4'h7, 6'h0, 6'h0, 16'h8000, 64'h001F_FFFF_FFFF_FFFF, 6'h0, 4'h0);
    op(32'h0, 4'h8, 6'h0, 6'h0, 16'h8000, 64'h0000_0000_8000_0000, 6'h20, 4'h0);
    op(32'h0, 4'h8, 6'h0, 6'h0, 16'h8000, 64'hFFFF_FFFF_8000_0000, 6'h0, 4'h0);
    op(32'h0, 4'h9, 6'h0, 6'h0, 16'h8000, 64'h0010_0000_0000_0000, 6'h20, 4'h0);
    op(32'h0, 4'h9, 6'h0, 6'h0, 16'h8000, 64'hFFF0_0000_0000_0000, 6'h0, 4'h0);
    op(32'h0, 4'h0, 6'h0, 6'h0, 16'h8140, 64'h0, 6'h20, 4'h0);
    op(32'h0100_0000, 4'h0, 6'h0, 6'h0, 16'h8150, 64'h0, 6'h3, 4'hd);
    op(32'h0100_0002, 4'h0, 6'h0, 6'h0, 16'h8140, 64'h0, 6'h3, 4'h4);
    op(32'h0100_0003, 4'h0, 6'h0, 6'h0, 16'h8150, 64'h0, 6'h3, 4'hc);
    op(32'h0100_0100, 4'h0, 6'h0, 6'h0, 16'h8140, 64'h0, 6'h20, 4'h0);
    op(32'h80, 4'h0, 6'h0, 6'h0, 16'h4100, 64'h0, 6'h1, 4'h0);
    op(32'h200, 4'h0, 6'h0, 6'h0, 16'h8180, 64'h0, 6'h5, 4'h0);
    op(32'h0100_0000, 4'h0, 6'h0, 6'h0, 16'h8060, 64'h0, 6'h0, 4'h0);
    op(32'h0100_0000, 4'h0, 6'h0, 6'h0, 16'h8040, 64'h0, 6'h1, 4'h5);
    op(32'h2, 4'h0, 6'h0, 6'h0, 16'h8190, 64'h0, 6'h5, 4'hb);
    op(32'h3, 4'h0, 6'h0, 6'h0, 16'h8180, 64'h0, 6'h5, 4'h3);
    op(32'h0, 4'h0, 6'h0, 6'h0, 16'h8400, 64'h0, 6'h20, 4'h0);
    op(32'h0, 4'ha, 6'h10, 6'h0, 16'h8000, 64'h0, 6'h20, 4'h0);
    op(32'h0, 4'hb, 6'h0, 6'h0, 16'h8004, 64'h0, 6'h20, 4'h0);
    op(32'h0, 4'hb, 6'h0, 6'h0, 16'h8002, 64'h0, 6'h20, 4'h0);
    op(32'h0, 4'h7, 6'h0, 6'h0, 16'h8001, 64'h0, 6'h20, 4'h0);
    op(32'h400, 4'h2, 6'h20, 6'h8, 16'h8000, 64'h0, 6'h8, 4'h0);
    end_sim;
  end
endmodule // fdx_exception_unit_tb_top
bind fdx_exception_unit fdx_exception_unit_monitor #(.TRAP_CODE(TRAP_CODE)) u_mon (.clk_i(clk_i),
  .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .op_issue_i(op_issue_i), .may_except_i(may_except_i), .op_done_i(op_done_i), .stall_o(stall_o),
  .wr_en_o(wr_en_o), .trap_o(trap_o), .trap_code_o(trap_code_o));
